/* File: cap_sense_pkg.sv */
// constants for the capacitive sense result and tuning control register bank
// assumes byte-wide register access with a low/high byte select per address
package cap_sense_pkg;

  localparam int       CHANNELS         = 7;
  localparam int       TRACK_CHANNELS   = 6;
  localparam int       COUNT_W          = 16;

  localparam logic [7:0] ADDR_REF_FIRST   = 8'h0E;
  localparam logic [7:0] ADDR_REF_LAST    = 8'h12;
  localparam logic [7:0] ADDR_DELTA_FIRST = 8'h13;
  localparam logic [7:0] ADDR_DELTA_LAST  = 8'h19;
  localparam logic [7:0] ADDR_SETTINGS    = 8'h80;

  localparam logic [7:0] SETTINGS_ZERO_RESET = 8'h00;
  localparam logic [7:0] SETTINGS_ONE_RESET  = 8'h11;
  localparam logic [7:0] READ_ZERO           = 8'h00;

  // sensing_settings_zero bit positions
  localparam int S0_HALT      = 0;
  localparam int S0_EXTEND    = 1;
  localparam int S0_TALK      = 2;
  localparam int S0_RESEED    = 3;
  localparam int S0_RETUNE    = 4;
  localparam int S0_WIDE      = 5;
  localparam int S0_PARTIAL   = 6;
  localparam int S0_AUTO_OFF  = 7;

  // sensing_settings_one field positions
  localparam int S1_ACF_LO    = 0;
  localparam int S1_LTA_LO    = 4;
  localparam int S1_EVENT     = 6;
  localparam int S1_WDT_OFF   = 7;

  // lta beta 1/512 is a shift of 9; each step of the field doubles it
  localparam logic [3:0] LTA_SHIFT_BASE = 4'h9;

  localparam int CLK_PERIOD_NS     = 20;
  localparam int SETTLE_NORMAL_NS  = 200;
  localparam int SETTLE_EXTEND_NS  = 800;
  localparam logic [7:0] SETTLE_NORMAL_CYC =
    8'((SETTLE_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SETTLE_EXTEND_CYC =
    8'((SETTLE_EXTEND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

/* File: filter_step.sv */
// one step of a first-order filter: cur moves toward target by diff >> shift
// assumes shift of zero means follow the target directly
`timescale 1ns/100ps
module filter_step
  import cap_sense_pkg::*;
(
  input  wire logic [COUNT_W-1:0] cur,
  input  wire logic [COUNT_W-1:0] target,
  input  wire logic [3:0]         shift,
  output logic      [COUNT_W-1:0] nxt
);

  logic signed [COUNT_W:0] diff;
  logic signed [COUNT_W:0] step;

  assign diff = $signed({1'b0, target}) - $signed({1'b0, cur});
  assign step = diff >>> shift;
  // small positive differences truncate to no movement; small negative ones still step down by one
  assign nxt  = cur + step[COUNT_W-1:0];

endmodule

/* File: cap_sense_regs.sv */
// result and tuning-control register bank of a capacitive trackpad controller
// assumes the link front end delivers decoded byte accesses synchronous to clk
`timescale 1ns/100ps

// What this block does
// - Reference values of trackpad channels 0 to 4 are read-only 16-bit words at 0x0E..0x12, low byte then high byte.
// - Delta values are read-only 16-bit words at 0x13..0x19, split into a low and a high byte.
// - The wake channel delta is its long-term average minus its filtered count.
// - Each trackpad channel delta is its filtered count minus its stored reference.
// - Without the talk-while-tuning bit the device does not communicate during tuning; with it, it may.
// - The extend-settling bit selects a longer analogue settling time than normal.
// - The first settings register is a read-write byte at 0x80 low half that resets to 0x00.
// - A link timeout resets the device unless the watchdog-disable bit is set.
// - The event-mode bit picks streaming (0) or event-driven (1) communication.
// - A two-bit field picks the wake channel average coefficient 1/512, 1/256, 1/128 or 1/64.
module cap_sense_regs
  import cap_sense_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic                          reg_high_byte,
  input  wire logic                          reg_write,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  input  wire logic [COUNT_W-1:0]            raw_count_ch0,
  input  wire logic [TRACK_CHANNELS*COUNT_W-1:0] track_filtered_count,
  input  wire logic                          sample_valid,
  input  wire logic                          tuning_busy,
  input  wire logic                          link_timeout,
  output logic                               tuning_start,
  output logic                               tuning_partial,
  output logic                               tuning_window_wide,
  output logic                               auto_tuning_disable,
  output logic                               comms_allowed,
  output logic      [7:0]                    settle_cycles,
  output logic                               event_mode,
  output logic                               self_reset_req
);

  function automatic logic [3:0] lta_shift(input logic [1:0] sel);
    lta_shift = LTA_SHIFT_BASE - {2'b00, sel};
  endfunction

  logic [7:0]         settings_zero_r;
  logic [7:0]         settings_zero_nxt;
  logic [7:0]         settings_one_r;
  logic [7:0]         reg_rdata_nxt;
  logic [COUNT_W-1:0] long_term_average_r;
  logic [COUNT_W-1:0] lta_nxt;
  logic [COUNT_W-1:0] ac_filtered_count_r;
  logic [COUNT_W-1:0] acf_nxt;
  logic [COUNT_W-1:0] ref_r   [TRACK_CHANNELS];
  logic [COUNT_W-1:0] ref_nxt [TRACK_CHANNELS];
  logic [COUNT_W-1:0] track_acf [TRACK_CHANNELS];
  logic [COUNT_W-1:0] delta   [CHANNELS];

  wire       wr_s0      = reg_write && reg_addr == ADDR_SETTINGS && !reg_high_byte;
  wire       wr_s1      = reg_write && reg_addr == ADDR_SETTINGS && reg_high_byte;
  wire       force_halt = settings_zero_r[S0_HALT];
  wire       reseed     = settings_zero_r[S0_RESEED];
  wire [1:0] lta_sel    = settings_one_r[S1_LTA_LO +: 2];
  wire [1:0] acf_sel    = settings_one_r[S1_ACF_LO +: 2];
  wire       track_upd  = sample_valid && !force_halt;

  // wake channel ac filter; field 0 bypasses it, and field 1 (a shift of 1) is a half-step
  filter_step u_acf0 (
    .cur    (ac_filtered_count_r),
    .target (raw_count_ch0),
    .shift  ({2'b00, acf_sel}),
    .nxt    (acf_nxt)
  );

  filter_step u_lta0 (
    .cur    (long_term_average_r),
    .target (ac_filtered_count_r),
    .shift  (lta_shift(lta_sel)),
    .nxt    (lta_nxt)
  );

  genvar g;
  generate
    for (g = 0; g < TRACK_CHANNELS; g++) begin : g_track
      assign track_acf[g] = track_filtered_count[g*COUNT_W +: COUNT_W];
      filter_step u_ref (
        .cur    (ref_r[g]),
        .target (track_acf[g]),
        .shift  (lta_shift(lta_sel)),
        .nxt    (ref_nxt[g])
      );
      assign delta[g+1] = track_acf[g] - ref_r[g];

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          ref_r[g] <= '0;
        end else if (reseed) begin
          ref_r[g] <= track_acf[g];
        end else if (track_upd) begin
          ref_r[g] <= ref_nxt[g];
        end
      end
    end
  endgenerate

  assign delta[0] = long_term_average_r - ac_filtered_count_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ac_filtered_count_r <= '0;
    end else if (sample_valid) begin
      ac_filtered_count_r <= (acf_sel == 2'b00) ? raw_count_ch0 : acf_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      long_term_average_r <= '0;
    end else if (reseed) begin
      long_term_average_r <= ac_filtered_count_r;
    end else if (track_upd) begin
      long_term_average_r <= lta_nxt;
    end
  end

  // self-clearing bits: a fresh write of 1 wins over the hardware clear
  always_comb begin
    settings_zero_nxt = settings_zero_r;
    settings_zero_nxt[S0_RETUNE] = 1'b0;
    settings_zero_nxt[S0_RESEED] = 1'b0;
    if (wr_s0) begin
      settings_zero_nxt = reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      settings_zero_r <= SETTINGS_ZERO_RESET;
      settings_one_r  <= SETTINGS_ONE_RESET;
    end else begin
      settings_zero_r <= settings_zero_nxt;
      if (wr_s1) begin
        settings_one_r <= reg_wdata;
      end
    end
  end

  // read path; reference and delta space ignores writes
  wire        in_ref    = reg_addr >= ADDR_REF_FIRST && reg_addr <= ADDR_REF_LAST;
  wire        in_delta  = reg_addr >= ADDR_DELTA_FIRST && reg_addr <= ADDR_DELTA_LAST;
  wire [7:0]  ref_idx   = reg_addr - ADDR_REF_FIRST;
  wire [7:0]  delta_idx = reg_addr - ADDR_DELTA_FIRST;
  wire [15:0] ref_word  = ref_r[ref_idx[2:0]];
  wire [15:0] dlt_word  = delta[delta_idx[2:0]];

  always_comb begin
    reg_rdata_nxt = READ_ZERO;
    if (in_ref) begin
      reg_rdata_nxt = reg_high_byte ? ref_word[15:8] : ref_word[7:0];
    end else if (in_delta) begin
      reg_rdata_nxt = reg_high_byte ? dlt_word[15:8] : dlt_word[7:0];
    end else if (reg_addr == ADDR_SETTINGS) begin
      reg_rdata_nxt = reg_high_byte ? settings_one_r : settings_zero_r;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= READ_ZERO;
    end else begin
      reg_rdata <= reg_rdata_nxt;
    end
  end

  assign tuning_start        = settings_zero_r[S0_RETUNE];
  assign tuning_partial      = settings_zero_r[S0_PARTIAL];
  assign tuning_window_wide  = settings_zero_r[S0_WIDE];
  assign auto_tuning_disable = settings_zero_r[S0_AUTO_OFF];
  assign comms_allowed       = !tuning_busy || settings_zero_r[S0_TALK];
  assign settle_cycles       = settings_zero_r[S0_EXTEND] ? SETTLE_EXTEND_CYC
                                                          : SETTLE_NORMAL_CYC;
  assign event_mode          = settings_one_r[S1_EVENT];
  assign self_reset_req      = link_timeout && !settings_one_r[S1_WDT_OFF];

  a_retune_start: assert property (@(posedge clk) disable iff (reset)
    (wr_s0 && reg_wdata[S0_RETUNE]) |=> tuning_start ##1 (!tuning_start || $past(wr_s0)))
    else $error("retune write did not pulse tuning start once");

  a_reseed_load: assert property (@(posedge clk) disable iff (reset)
    reseed |=> (long_term_average_r == $past(ac_filtered_count_r)) && (!reseed || $past(wr_s0)))
    else $error("reseed did not load average or did not clear");

  a_halt_freeze: assert property (@(posedge clk) disable iff (reset)
    (force_halt && !reseed) |=> $stable(long_term_average_r) && $stable(ref_r[0]))
    else $error("forced halt let average or reference move");

  a_wake_delta: assert property (@(posedge clk) disable iff (reset)
    (reg_addr == ADDR_DELTA_FIRST && !reg_high_byte) |=>
      reg_rdata == $past(long_term_average_r[7:0] - ac_filtered_count_r[7:0]))
    else $error("wake delta read wrong");

  a_track_delta: assert property (@(posedge clk) disable iff (reset)
    (reg_addr == ADDR_DELTA_FIRST + 8'h01 && reg_high_byte) |=>
      reg_rdata == $past(track_acf[0][15:8] - ref_r[0][15:8]
                         - {7'h00, track_acf[0][7:0] < ref_r[0][7:0]}))
    else $error("trackpad delta high byte wrong");

  a_comms_gate: assert property (@(posedge clk) disable iff (reset)
    (tuning_busy && !settings_zero_r[S0_TALK]) |-> !comms_allowed)
    else $error("communication allowed during tuning");

  a_settle_pick: assert property (@(posedge clk) disable iff (reset)
    (wr_s0 && reg_wdata[S0_EXTEND]) |=> settle_cycles == SETTLE_EXTEND_CYC)
    else $error("extended settling not selected");

  a_watchdog_reset: assert property (@(posedge clk) disable iff (reset)
    link_timeout |-> (self_reset_req == !settings_one_r[S1_WDT_OFF]))
    else $error("timeout did not request reset");

  a_ro_space: assert property (@(posedge clk) disable iff (reset)
    (reg_write && in_ref) |=> ($stable(settings_zero_r) || $past(reseed) || $past(tuning_start))
      && ($stable(ref_r[0]) || $past(reseed) || $past(track_upd)))
    else $error("write to reference space changed settings");

  a_acf_bypass: assert property (@(posedge clk) disable iff (reset)
    (sample_valid && acf_sel == 2'b00) |=> ac_filtered_count_r == $past(raw_count_ch0))
    else $error("filter off did not pass raw count");

endmodule

/* File: host_model.sv */
// host side of the register port: byte reads and writes
// assumes requests launch 1 ns after a rising clk edge
`timescale 1ns/100ps
module host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_high_byte,
  output logic            reg_write,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_high_byte = 1'b0;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic h, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_high_byte = h;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clk);
    #1;
    reg_write = 1'b0;
    // stale data must never pass for a fresh write
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, input logic h, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_high_byte = h;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
endmodule

/* File: tb_top.sv */
// self-checking bench for the result and tuning settings register bank
// assumes host_model owns the register port; this bench drives the counts
`timescale 1ns/100ps
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); \
  end \
end
module tb_top;
  import cap_sense_pkg::*;
  logic        clk, reset, reg_high_byte, reg_write;
  logic        sample_valid, tuning_busy, link_timeout, tuning_start, tuning_partial;
  logic        tuning_window_wide, auto_tuning_disable, comms_allowed, event_mode;
  logic        self_reset_req;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, settle_cycles, v0, v1, d;
  logic [15:0] raw_count_ch0, ca, cb, e, cc, ea, el, er;
  logic [95:0] track_filtered_count, ta, tb_;
  integer      seed = 37;
  int          error_cnt, checked, n;

  host_model i_host_model (.clk(clk), .reg_addr(reg_addr), .reg_high_byte(reg_high_byte),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  cap_sense_regs i_cap_sense_regs (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_high_byte(reg_high_byte), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .raw_count_ch0(raw_count_ch0),
    .track_filtered_count(track_filtered_count), .sample_valid(sample_valid),
    .tuning_busy(tuning_busy), .link_timeout(link_timeout), .tuning_start(tuning_start),
    .tuning_partial(tuning_partial), .tuning_window_wide(tuning_window_wide),
    .auto_tuning_disable(auto_tuning_disable), .comms_allowed(comms_allowed),
    .settle_cycles(settle_cycles), .event_mode(event_mode), .self_reset_req(self_reset_req));

  task automatic smp(input logic [95:0] t, input logic [15:0] c);
    @(posedge clk);
    #1;
    track_filtered_count = t;
    raw_count_ch0 = c;
    sample_valid = 1'b1;
    @(posedge clk);
    #1;
    sample_valid = 1'b0;
  endtask

  // reference model of one filter step: move toward the target by the difference shifted down
  function automatic logic [15:0] flt(input int cur, input int tgt, input int sh);
    flt = 16'(cur + ((tgt - cur) >>> sh));
  endfunction

  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // generous bound: the sequence needs well under a thousand cycles
  initial begin
    #(CLK_PERIOD_NS * 4000);
    error_cnt++;
    results();
  end

  initial begin
    reset = 1'b1;
    raw_count_ch0 = 16'h0000;
    track_filtered_count = '0;
    sample_valid = 1'b0;
    tuning_busy = 1'b0;
    link_timeout = 1'b0;
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    i_host_model.rd(ADDR_SETTINGS, 1'b0, d);
    `CHK(d, SETTINGS_ZERO_RESET)
    i_host_model.rd(ADDR_SETTINGS, 1'b1, d);
    `CHK(d, SETTINGS_ONE_RESET)
    i_host_model.rd(8'h20, 1'b0, d);
    `CHK(d, READ_ZERO)
    // reseed stays clear here so the averages keep their reset values
    for (n = 0; n < 8; n++) begin
      v0 = 8'($random(seed)) & 8'hF7;
      v1 = 8'($random(seed));
      i_host_model.wr(ADDR_SETTINGS, 1'b0, v0);
      `CHK(tuning_start, v0[S0_RETUNE])
      tuning_busy = 1'($random(seed));
      link_timeout = 1'b1;
      i_host_model.wr(ADDR_SETTINGS, 1'b1, v1);
      `CHK(self_reset_req, ~v1[S1_WDT_OFF])
      `CHK(event_mode, v1[S1_EVENT])
      `CHK(comms_allowed, ~tuning_busy | v0[S0_TALK])
      `CHK(settle_cycles, v0[S0_EXTEND] ? SETTLE_EXTEND_CYC : SETTLE_NORMAL_CYC)
      `CHK({auto_tuning_disable, tuning_partial, tuning_window_wide}, v0[7:5])
      link_timeout = 1'b0;
      i_host_model.rd(ADDR_SETTINGS, 1'b0, d);
      `CHK(d, v0 & 8'hEF)
      i_host_model.rd(ADDR_SETTINGS, 1'b1, d);
      `CHK(d, v1)
    end
    i_host_model.wr(ADDR_SETTINGS, 1'b1, 8'h00);
    i_host_model.wr(ADDR_SETTINGS, 1'b0, 8'h01);
    ta = {$random(seed), $random(seed), $random(seed)};
    ca = 16'($random(seed));
    smp(ta, ca);
    i_host_model.wr(ADDR_SETTINGS, 1'b0, 8'h09);
    @(posedge clk);
    i_host_model.rd(ADDR_SETTINGS, 1'b0, d);
    `CHK(d, 8'h01)
    tb_ = {$random(seed), $random(seed), $random(seed)};
    cb = 16'($random(seed));
    smp(tb_, cb);
    // a write into the read-only block must leave the reference alone
    i_host_model.wr(ADDR_REF_FIRST, 1'b0, 8'h5A);
    for (n = 0; n < 12; n++) begin
      if (n < 5) e = ta[16*n +: 16];
      else if (n == 5) e = ca - cb;
      else e = tb_[16*(n-6) +: 16] - ta[16*(n-6) +: 16];
      i_host_model.rd(ADDR_REF_FIRST + 8'(n), 1'b0, d);
      `CHK(d, e[7:0])
      i_host_model.rd(ADDR_REF_FIRST + 8'(n), 1'b1, d);
      `CHK(d, e[15:8])
    end
    // release the halt and run one sample with the filter on and the fastest average
    i_host_model.wr(ADDR_SETTINGS, 1'b1, 8'h31);
    i_host_model.wr(ADDR_SETTINGS, 1'b0, 8'h00);
    cc = 16'($random(seed));
    smp(tb_, cc);
    ea = flt(cb, cc, 1);
    el = flt(ca, cb, 6);
    er = flt(ta[15:0], tb_[15:0], 6);
    for (n = 0; n < 6; n++) begin
      e = (n < 2) ? er : (n < 4) ? 16'(el - ea) : 16'(tb_[15:0] - er);
      i_host_model.rd(n < 2 ? ADDR_REF_FIRST : ADDR_DELTA_FIRST + 8'(n/2 - 1), n[0], d);
      `CHK(d, n[0] ? e[15:8] : e[7:0])
    end
    results();
  end
endmodule
